//--- rtl/ecub_pkg.sv
// Purpose: Shared constants for the extended control upper-bit bank
// Assumes: 50 MHz mclk, 16-bit register byte addresses
// Notes:   Bit positions are those of the extended device control word, except the valid bit of the speed status register
package ecub_pkg;
    // ========================================================
    // Register map
    localparam logic [15:0] ECUB_EXT_CTRL_OFF   = 16'h0018;
    localparam logic [15:0] ECUB_SPD_STATUS_OFF = 16'h0100;

    // ========================================================
    // Field positions
    localparam int ECUB_PIN3_DIR_BIT   = 11;
    localparam int ECUB_ASD_CHK_BIT    = 12;
    localparam int ECUB_RSVD14_BIT     = 14;
    localparam int ECUB_SPD_BYPASS_BIT = 15;
    localparam int ECUB_NS_OFF_BIT     = 16;
    localparam int ECUB_RO_OFF_BIT     = 17;
    localparam int ECUB_CLK_GATE_BIT   = 19;
    localparam int ECUB_PHY_PD_BIT     = 20;
    localparam int ECUB_RSVD21_BIT     = 21;
    localparam int ECUB_SPD_VALID_BIT  = 2;

    // ========================================================
    // Reset values
    localparam logic ECUB_PIN3_DIR_RST   = 1'h0;
    localparam logic ECUB_SPD_BYPASS_RST = 1'h0;
    localparam logic ECUB_NS_OFF_RST     = 1'h0;
    localparam logic ECUB_RO_OFF_RST     = 1'h0;
    localparam logic ECUB_CLK_GATE_RST   = 1'h0;
    localparam logic ECUB_PHY_PD_RST     = 1'h1;

    // ========================================================
    // Speed measurement timing
    localparam int ECUB_MCLK_KHZ      = 50000;
    localparam int ECUB_ASD_WINDOW_NS = 1280;
    localparam int ECUB_ASD_CYCLES    = (ECUB_ASD_WINDOW_NS * ECUB_MCLK_KHZ) / 1000000;
    localparam logic [7:0] ECUB_ASD_LAST    = 8'(ECUB_ASD_CYCLES - 1);
    localparam logic [7:0] ECUB_ASD_THR_LOW = 8'h08;
    localparam logic [7:0] ECUB_ASD_THR_MID = 8'h18;

    // ========================================================
    // Speed codes
    localparam logic [1:0] ECUB_SPEED_10   = 2'h0;
    localparam logic [1:0] ECUB_SPEED_100  = 2'h1;
    localparam logic [1:0] ECUB_SPEED_1000 = 2'h2;
endpackage : ecub_pkg

//--- rtl/ecub_link_if.sv
// Purpose: Carries speed check and pin 3 signals between the bank and its helpers
// Assumes: All signals on mclk
// Notes:   No clocking block; plain nets only
`timescale 1ns/1ps
`default_nettype none
interface ecub_link_if;
    logic       asd_start;
    logic       asd_busy;
    logic       asd_done;
    logic [1:0] asd_result;
    logic       pin3_dir;
    logic       pin3_drive;
    logic       pin3_irq_en;
    logic       pin3_level;
    logic       pin3_gpi;

    modport ctl (output asd_start, input asd_busy, input asd_done, input asd_result,
                 output pin3_dir, output pin3_drive, output pin3_irq_en,
                 input pin3_level, input pin3_gpi);
    modport chk (input asd_start, output asd_busy, output asd_done, output asd_result);
    modport pin (input pin3_dir, input pin3_drive, input pin3_irq_en,
                 output pin3_level, output pin3_gpi);
endinterface : ecub_link_if
`default_nettype wire

//--- rtl/ecub_speed_check.sv
// Purpose: One-shot receive clock frequency measurement
// Assumes: rx_clk_pin is asynchronous to mclk
// Notes:   Edges are counted after sampling, so the gigabit clock aliases;
//          anything at or above the mid threshold is reported as gigabit
`timescale 1ns/1ps
`default_nettype none
module ecub_speed_check
    import ecub_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic rx_clk_pin,
    ecub_link_if.chk  link
);
    typedef enum {ECUB_ASD_IDLE, ECUB_ASD_MEASURE} ecub_asd_state_t;

    typedef struct packed {
        ecub_asd_state_t state;
        logic            sync1;
        logic            sync2;
        logic            prev;
        logic [7:0]      cycles;
        logic [7:0]      edges;
        logic [1:0]      result;
        logic            done;
    } ecub_asd_st_t;

    ecub_asd_st_t st_reg;
    ecub_asd_st_t st_next;

    // ========================================================
    // Measurement sequence
    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = rx_clk_pin;
        st_next.sync2 = st_reg.sync1;
        st_next.prev  = st_reg.sync2;
        st_next.done  = 1'b0;
        case (st_reg.state)
            ECUB_ASD_IDLE: begin
                if (link.asd_start) begin // RQ3
                    st_next.state  = ECUB_ASD_MEASURE;
                    st_next.cycles = 8'h00;
                    st_next.edges  = 8'h00;
                end
            end
            ECUB_ASD_MEASURE: begin
                st_next.cycles = st_reg.cycles + 8'h01;
                if (st_reg.sync2 && !st_reg.prev) begin
                    st_next.edges = st_reg.edges + 8'h01;
                end
                if (st_reg.cycles == ECUB_ASD_LAST) begin // RQ3
                    st_next.state = ECUB_ASD_IDLE;
                    st_next.done  = 1'b1;
                    if (st_reg.edges < ECUB_ASD_THR_LOW) begin
                        st_next.result = ECUB_SPEED_10;
                    end else if (st_reg.edges < ECUB_ASD_THR_MID) begin
                        st_next.result = ECUB_SPEED_100;
                    end else begin
                        st_next.result = ECUB_SPEED_1000;
                    end
                end
            end
            default: st_next.state = ECUB_ASD_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{ECUB_ASD_IDLE, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, ECUB_SPEED_10, 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.asd_busy   = (st_reg.state == ECUB_ASD_MEASURE); // RQ13
    assign link.asd_done   = st_reg.done;
    assign link.asd_result = st_reg.result;

    // ========================================================
    // Checks
    chk_asd_run_length: assert property (@(posedge mclk) disable iff (!rst_n) // RQ13
        (link.asd_start && !link.asd_busy) |=> link.asd_busy [*8] ##56 link.asd_busy ##1
        (link.asd_done && !link.asd_busy))
        else $error("speed check did not finish after its window");
endmodule : ecub_speed_check
`default_nettype wire

//--- rtl/ecub_pin3.sv
// Purpose: Software pin 3 direction, drive and interrupt detection
// Assumes: pin3_in comes from a pad, asynchronous to mclk
// Notes:   Output enable is active low
`timescale 1ns/1ps
`default_nettype none
module ecub_pin3
    import ecub_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic pin3_in,
    output logic      pin3_out,
    output logic      pin3_oe_n,
    ecub_link_if.pin  link
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic out;
        logic oe_n;
        logic gpi;
    } ecub_pin_st_t;

    ecub_pin_st_t st_reg;
    ecub_pin_st_t st_next;

    // ========================================================
    // Pin control
    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = pin3_in;
        st_next.sync2 = st_reg.sync1;
        st_next.out   = link.pin3_drive;
        st_next.oe_n  = !link.pin3_dir; // RQ1
        st_next.gpi   = !link.pin3_dir && link.pin3_irq_en && st_reg.sync2; // RQ12
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pin3_out        = st_reg.out;
    assign pin3_oe_n       = st_reg.oe_n;
    assign link.pin3_level = st_reg.sync2;
    assign link.pin3_gpi   = st_reg.gpi;

    // ========================================================
    // Checks
    chk_gpi_cause_raise: assert property (@(posedge mclk) disable iff (!rst_n) // RQ12
        (!link.pin3_dir && link.pin3_irq_en && st_reg.sync2) |=> link.pin3_gpi)
        else $error("pin 3 interrupt cause not raised");
    chk_pin3_oe_dir: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
        link.pin3_dir |=> !pin3_oe_n && (pin3_out == $past(link.pin3_drive)))
        else $error("pin 3 not driven as an output");
endmodule : ecub_pin3
`default_nettype wire

//--- rtl/ecub_ext_ctrl.sv
// Purpose: Upper bits 11 to 21 of the extended device control register
// Assumes: rst_n is the power-on reset; sw_rst and sys_rst are one-cycle
//          pulses on mclk; nvm_load strobes configuration once after power-on
// Notes:   Read data appear the cycle after the read strobe
//
// Summary of operation
// RQ1: Bit 11 sets pin 3 direction, nonvolatile initial
// RQ2: Pin direction survives software and system reset
// RQ3: Writing bit 12 starts receive clock measurement
// RQ4: Bypass bit adopts software speed at once
// RQ5: No-snoop off clears every no-snoop attribute
// RQ6: Otherwise no-snoop follows configuration and enables
// RQ7: Relaxed-order off blocks relaxed ordering always
// RQ8: Otherwise relaxed ordering follows queue controls
// RQ9: Bit 19 enables dynamic MAC clock gating
// RQ10: Bit 20 allows PHY power down, default one
// RQ11: Software writes reserved bits zero, ignores reads
// RQ12: Input pin 3 high raises cause fourteen
// RQ13: Check bit reads one while measuring
`timescale 1ns/1ps
`default_nettype none
module ecub_ext_ctrl
    import ecub_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        sw_rst,
    input  wire logic        sys_rst,
    input  wire logic        nvm_load,
    input  wire logic        nvm_pin3_dir,
    input  wire logic        nvm_clk_gate,
    input  wire logic        nvm_phy_pd,
    input  wire logic [15:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [1:0]  ctrl_speed,
    input  wire logic [1:0]  hw_speed,
    output logic      [1:0]  speed_sel,
    output logic             speed_select_bypass,
    output logic      [1:0]  speed_detect_result,
    input  wire logic        rx_clk_pin,
    input  wire logic        no_snoop_request,
    output logic             no_snoop_attr,
    input  wire logic        pcie_devctl_ro,
    input  wire logic        queue_ro_request,
    output logic             relaxed_order_attr,
    output logic             mac_clock_gate_en,
    output logic             phy_power_down_en,
    output logic             pin3_direction,
    input  wire logic        pin3_drive_value,
    input  wire logic        pin3_interrupt_enable,
    input  wire logic        pin3_in,
    output logic             pin3_out,
    output logic             pin3_oe_n,
    output logic             pin3_level,
    output logic             gpi_cause_pin3
);
    // ========================================================
    // State
    typedef struct packed {
        logic        pin3_dir;
        logic        spd_bypass;
        logic        ns_off;
        logic        ro_off;
        logic        clk_gate;
        logic        phy_pd;
        logic        asd_start;
        logic        spd_valid;
        logic [1:0]  spd_result;
        logic [1:0]  speed_sel;
        logic        ns_attr;
        logic        ro_attr;
        logic [31:0] rdata;
    } ecub_main_st_t;

    localparam ecub_main_st_t ECUB_MAIN_RST = '{
        pin3_dir:   ECUB_PIN3_DIR_RST,
        spd_bypass: ECUB_SPD_BYPASS_RST,
        ns_off:     ECUB_NS_OFF_RST,
        ro_off:     ECUB_RO_OFF_RST,
        clk_gate:   ECUB_CLK_GATE_RST,
        phy_pd:     ECUB_PHY_PD_RST,
        asd_start:  1'b0,
        spd_valid:  1'b0,
        spd_result: ECUB_SPEED_10,
        speed_sel:  ECUB_SPEED_10,
        ns_attr:    1'b0,
        ro_attr:    1'b0,
        rdata:      32'h0000_0000
    };

    ecub_main_st_t st_reg;
    ecub_main_st_t st_next;

    ecub_link_if link ();

    logic        wr_ext;
    logic        soft_rst;
    logic [31:0] ext_view;
    logic [31:0] spd_view;

    assign wr_ext   = reg_wr && (reg_addr == ECUB_EXT_CTRL_OFF);
    assign soft_rst = sw_rst || sys_rst;

    // ========================================================
    // Helpers
    ecub_speed_check u_speed_check (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .rx_clk_pin (rx_clk_pin),
        .link       (link.chk)
    );

    ecub_pin3 u_pin3 (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .pin3_in   (pin3_in),
        .pin3_out  (pin3_out),
        .pin3_oe_n (pin3_oe_n),
        .link      (link.pin)
    );

    assign link.asd_start   = st_reg.asd_start;
    assign link.pin3_dir    = st_reg.pin3_dir;
    assign link.pin3_drive  = pin3_drive_value;
    assign link.pin3_irq_en = pin3_interrupt_enable;

    // ========================================================
    // Read views; reserved bits, control bits 0 to 10 and status bits above 2 read as zero
    always_comb begin
        ext_view                      = 32'h0000_0000;
        ext_view[ECUB_PIN3_DIR_BIT]   = st_reg.pin3_dir;
        // Pending start counts as busy so a read right after the write sees it
        ext_view[ECUB_ASD_CHK_BIT]    = st_reg.asd_start || link.asd_busy; // RQ13
        ext_view[ECUB_SPD_BYPASS_BIT] = st_reg.spd_bypass;
        ext_view[ECUB_NS_OFF_BIT]     = st_reg.ns_off;
        ext_view[ECUB_RO_OFF_BIT]     = st_reg.ro_off;
        ext_view[ECUB_CLK_GATE_BIT]   = st_reg.clk_gate;
        ext_view[ECUB_PHY_PD_BIT]     = st_reg.phy_pd;

        spd_view                      = 32'h0000_0000;
        spd_view[1:0]                 = st_reg.spd_result;
        spd_view[ECUB_SPD_VALID_BIT]  = st_reg.spd_valid;
    end

    // ========================================================
    // Next state
    always_comb begin
        st_next           = st_reg;
        st_next.asd_start = 1'b0;

        // Software writes; reserved bits 13, 14, 18 and 21 are dropped
        if (wr_ext) begin
            st_next.pin3_dir   = reg_wdata[ECUB_PIN3_DIR_BIT]; // RQ1
            st_next.spd_bypass = reg_wdata[ECUB_SPD_BYPASS_BIT];
            st_next.ns_off     = reg_wdata[ECUB_NS_OFF_BIT];
            st_next.ro_off     = reg_wdata[ECUB_RO_OFF_BIT];
            st_next.clk_gate   = reg_wdata[ECUB_CLK_GATE_BIT]; // RQ9
            st_next.phy_pd     = reg_wdata[ECUB_PHY_PD_BIT]; // RQ10
            // A second start while measuring is ignored
            st_next.asd_start  = reg_wdata[ECUB_ASD_CHK_BIT] && !link.asd_busy && !st_reg.asd_start; // RQ3
        end

        // Nonvolatile defaults arrive after power-on
        if (nvm_load) begin
            st_next.pin3_dir = nvm_pin3_dir; // RQ1
            st_next.clk_gate = nvm_clk_gate; // RQ9
            st_next.phy_pd   = nvm_phy_pd; // RQ10
        end

        // Software and system reset leave pin 3 direction alone
        if (soft_rst) begin // RQ2
            st_next.spd_bypass = ECUB_SPD_BYPASS_RST;
            st_next.ns_off     = ECUB_NS_OFF_RST;
            st_next.ro_off     = ECUB_RO_OFF_RST;
            st_next.clk_gate   = ECUB_CLK_GATE_RST;
            st_next.phy_pd     = ECUB_PHY_PD_RST;
            st_next.asd_start  = 1'b0;
        end

        // Measurement outcome
        if (link.asd_done) begin // RQ3
            st_next.spd_result = link.asd_result;
            st_next.spd_valid  = 1'b1;
        end else if (st_reg.asd_start) begin
            st_next.spd_valid  = 1'b0;
        end

        // Speed select: bypass skips the clock switching path
        st_next.speed_sel = st_reg.spd_bypass ? ctrl_speed : hw_speed; // RQ4

        // Packet attributes
        st_next.ns_attr = !st_reg.ns_off && no_snoop_request; // RQ5 RQ6
        st_next.ro_attr = !st_reg.ro_off && pcie_devctl_ro && queue_ro_request; // RQ7 RQ8

        // Register reads, answered one cycle later
        st_next.rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == ECUB_EXT_CTRL_OFF) begin
                st_next.rdata = ext_view;
            end else if (reg_addr == ECUB_SPD_STATUS_OFF) begin
                st_next.rdata = spd_view;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ECUB_MAIN_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ========================================================
    // Outputs
    assign reg_rdata           = st_reg.rdata;
    assign speed_sel           = st_reg.speed_sel;
    assign speed_select_bypass = st_reg.spd_bypass;
    assign speed_detect_result = st_reg.spd_result;
    assign no_snoop_attr       = st_reg.ns_attr;
    assign relaxed_order_attr  = st_reg.ro_attr;
    assign mac_clock_gate_en   = st_reg.clk_gate;
    assign phy_power_down_en   = st_reg.phy_pd;
    assign pin3_direction      = st_reg.pin3_dir;
    assign pin3_level          = link.pin3_level;
    assign gpi_cause_pin3      = link.pin3_gpi;

    // ========================================================
    // Checks
    chk_pin3_dir_write: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
        (wr_ext && !nvm_load)
        |=> pin3_direction == $past(reg_wdata[ECUB_PIN3_DIR_BIT]))
        else $error("pin 3 direction did not take the written value");

    chk_pin3_dir_nvm: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
        nvm_load
        |=> pin3_direction == $past(nvm_pin3_dir))
        else $error("pin 3 direction missed its default");

    chk_pin3_dir_hold: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
        (soft_rst && !wr_ext && !nvm_load)
        |=> $stable(pin3_direction))
        else $error("pin 3 direction changed on software or system reset");

    chk_asd_start_read: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
        (wr_ext && reg_wdata[ECUB_ASD_CHK_BIT] && !link.asd_busy && !st_reg.asd_start && !soft_rst)
        |=> link.asd_start ##1 link.asd_busy)
        else $error("speed check did not start");

    chk_result_posted: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
        link.asd_done
        |=> speed_detect_result == $past(link.asd_result))
        else $error("speed result not posted");

    chk_bypass_speed: assert property (@(posedge mclk) disable iff (!rst_n) // RQ4
        speed_select_bypass
        |=> speed_sel == $past(ctrl_speed))
        else $error("bypass did not adopt software speed");

    chk_ns_blocked: assert property (@(posedge mclk) disable iff (!rst_n) // RQ5
        (st_reg.ns_off && no_snoop_request)
        |=> !no_snoop_attr)
        else $error("no-snoop set while disabled");

    chk_ns_follow: assert property (@(posedge mclk) disable iff (!rst_n) // RQ6
        !st_reg.ns_off
        |=> no_snoop_attr == $past(no_snoop_request))
        else $error("no-snoop does not follow request");

    chk_ro_blocked: assert property (@(posedge mclk) disable iff (!rst_n) // RQ7
        (st_reg.ro_off && pcie_devctl_ro && queue_ro_request)
        |=> !relaxed_order_attr)
        else $error("relaxed ordering used while disabled");

    chk_ro_follow: assert property (@(posedge mclk) disable iff (!rst_n) // RQ8
        (!st_reg.ro_off && pcie_devctl_ro)
        |=> relaxed_order_attr == $past(queue_ro_request))
        else $error("relaxed ordering does not follow queue control");

    chk_clk_gate_write: assert property (@(posedge mclk) disable iff (!rst_n) // RQ9
        (wr_ext && !nvm_load && !soft_rst)
        |=> mac_clock_gate_en == $past(reg_wdata[ECUB_CLK_GATE_BIT]))
        else $error("clock gating enable did not take the written value");

    chk_phy_pd_reset: assert property (@(posedge mclk) disable iff (!rst_n) // RQ10
        soft_rst
        |=> phy_power_down_en && !mac_clock_gate_en)
        else $error("power-down enable not restored by reset");

    chk_busy_readback: assert property (@(posedge mclk) disable iff (!rst_n) // RQ13
        (reg_rd && reg_addr == ECUB_EXT_CTRL_OFF && link.asd_busy)
        |=> reg_rdata[ECUB_ASD_CHK_BIT])
        else $error("check bit read as zero while measuring");

    chk_check_bit_clear: assert property (@(posedge mclk) disable iff (!rst_n) // RQ13
        (reg_rd && reg_addr == ECUB_EXT_CTRL_OFF && !link.asd_busy && !st_reg.asd_start)
        |=> !reg_rdata[ECUB_ASD_CHK_BIT])
        else $error("check bit read as one while idle");
endmodule : ecub_ext_ctrl
`default_nettype wire

//--- verif/tb.sv
// Purpose: Self-checking bench for the extended control upper-bit bank
// Assumes: Register port answers a read one cycle after the strobe
// Notes:   Receive clock rates sit well inside each speed band so aliasing cannot flip the result
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin n_fail++; $display("mismatch at %0t: %s", $time, msg); end end
module tb
    import ecub_pkg::*;
;
    // ========================================================
    // Signals
    localparam logic [31:0] B11  = 32'h0000_0001 << ECUB_PIN3_DIR_BIT;
    localparam logic [31:0] B12  = 32'h0000_0001 << ECUB_ASD_CHK_BIT;
    localparam logic [31:0] B19  = 32'h0000_0001 << ECUB_CLK_GATE_BIT;
    localparam logic [31:0] B20  = 32'h0000_0001 << ECUB_PHY_PD_BIT;
    localparam logic [31:0] BALL = B11 | B19 | B20 | (32'h0000_0007 << ECUB_SPD_BYPASS_BIT);
    logic        mclk = 1'b0, rst_n = 1'b0, sw_rst = 1'b0, sys_rst = 1'b0, nvm_load = 1'b0;
    logic        nvm_pin3_dir = 1'b0, nvm_clk_gate = 1'b0, nvm_phy_pd = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rd;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic [1:0]  ctrl_speed = ECUB_SPEED_1000, hw_speed = ECUB_SPEED_10, speed_sel, speed_detect_result;
    logic        speed_select_bypass, rx_clk_pin = 1'b0, no_snoop_request = 1'b1, no_snoop_attr;
    logic        pcie_devctl_ro = 1'b1, queue_ro_request = 1'b1, relaxed_order_attr;
    logic        mac_clock_gate_en, phy_power_down_en, pin3_direction, pin3_drive_value = 1'b1;
    logic        pin3_interrupt_enable = 1'b1, pin3_in = 1'b0, pin3_out, pin3_oe_n, pin3_level, gpi_cause_pin3;
    int          n_fail = 0, n_checks = 0, rx_half = 0;
    int          halves [3] = '{401, 61, 21};
    logic [1:0]  exp_spd [3] = '{ECUB_SPEED_10, ECUB_SPEED_100, ECUB_SPEED_1000};

    // ========================================================
    // Clocks and design
    always #10 mclk = ~mclk;
    // Receive clock stands still between measurements
    always begin
        if (rx_half > 0) begin
            #(rx_half) rx_clk_pin = ~rx_clk_pin;
        end else begin
            #7;
        end
    end

    ecub_ext_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .sw_rst(sw_rst), .sys_rst(sys_rst), .nvm_load(nvm_load),
        .nvm_pin3_dir(nvm_pin3_dir), .nvm_clk_gate(nvm_clk_gate), .nvm_phy_pd(nvm_phy_pd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl_speed(ctrl_speed),
        .hw_speed(hw_speed), .speed_sel(speed_sel), .speed_select_bypass(speed_select_bypass),
        .speed_detect_result(speed_detect_result), .rx_clk_pin(rx_clk_pin), .no_snoop_request(no_snoop_request),
        .no_snoop_attr(no_snoop_attr), .pcie_devctl_ro(pcie_devctl_ro), .queue_ro_request(queue_ro_request),
        .relaxed_order_attr(relaxed_order_attr), .mac_clock_gate_en(mac_clock_gate_en),
        .phy_power_down_en(phy_power_down_en), .pin3_direction(pin3_direction), .pin3_drive_value(pin3_drive_value),
        .pin3_interrupt_enable(pin3_interrupt_enable), .pin3_in(pin3_in), .pin3_out(pin3_out),
        .pin3_oe_n(pin3_oe_n), .pin3_level(pin3_level), .gpi_cause_pin3(gpi_cause_pin3));

    // ========================================================
    // Tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cycles

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rdreg(input logic [15:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
        cycles(1);
        `CHK(reg_rdata, 32'h0000_0000, "read data held past one cycle")
    endtask : rdreg

    task automatic pulse_reset(input int kind);
        @(posedge mclk);
        sw_rst  <= (kind == 0);
        sys_rst <= (kind == 1);
        @(posedge mclk);
        sw_rst  <= 1'b0;
        sys_rst <= 1'b0;
        cycles(3);
    endtask : pulse_reset

    // ========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        cycles(1);
        rdreg(ECUB_EXT_CTRL_OFF, rd);
        `CHK(rd, B20, "power-on view")
        `CHK({phy_power_down_en, mac_clock_gate_en, pin3_oe_n}, 3'h5, "power-on outputs")
        $display("test power-on done");
        @(posedge mclk);
        nvm_pin3_dir <= 1'b1;
        nvm_clk_gate <= 1'b1;
        nvm_phy_pd   <= 1'b0;
        nvm_load     <= 1'b1;
        @(posedge mclk);
        nvm_load     <= 1'b0;
        rdreg(ECUB_EXT_CTRL_OFF, rd);
        `CHK(rd, B11 | B19, "nonvolatile defaults")
        `CHK({pin3_direction, pin3_oe_n, pin3_out, phy_power_down_en}, 4'hA, "pin driven as output")
        $display("test defaults done");
        wr(ECUB_EXT_CTRL_OFF, 32'hFFFF_EFFF);
        cycles(3);
        rdreg(ECUB_EXT_CTRL_OFF, rd);
        `CHK(rd, BALL, "reserved bits must read zero")
        `CHK(speed_sel, ctrl_speed, "bypass speed")
        `CHK({no_snoop_attr, relaxed_order_attr}, 2'h0, "attributes off")
        `CHK({mac_clock_gate_en, phy_power_down_en, speed_select_bypass}, 3'h7, "enables")
        wr(16'h001C, 32'h0000_0000);
        rdreg(16'h001C, rd);
        `CHK(rd, 32'h0000_0000, "unmapped read")
        rdreg(ECUB_EXT_CTRL_OFF, rd);
        `CHK(rd, BALL, "unmapped write leaked")
        $display("test write all done");
        for (int k = 0; k < 2; k++) begin
            wr(ECUB_EXT_CTRL_OFF, BALL);
            pulse_reset(k);
            rdreg(ECUB_EXT_CTRL_OFF, rd);
            `CHK(rd, B11 | B20, "direction survives reset")
            `CHK({no_snoop_attr, relaxed_order_attr}, 2'h3, "attributes follow requests")
            `CHK(speed_sel, hw_speed, "hardware speed")
        end
        $display("test soft resets done");
        wr(ECUB_EXT_CTRL_OFF, B20);
        @(posedge mclk);
        pin3_in <= 1'b1;
        cycles(5);
        `CHK({gpi_cause_pin3, pin3_level, pin3_oe_n}, 3'h7, "input pin interrupt")
        @(posedge mclk);
        pin3_interrupt_enable <= 1'b0;
        cycles(3);
        `CHK(gpi_cause_pin3, 1'b0, "interrupt while disabled")
        @(posedge mclk);
        pin3_interrupt_enable <= 1'b1;
        wr(ECUB_EXT_CTRL_OFF, B11 | B20);
        cycles(3);
        `CHK(gpi_cause_pin3, 1'b0, "interrupt while output")
        $display("test pin three done");
        for (int i = 0; i < 3; i++) begin
            rx_half = halves[i];
            cycles(2);
            wr(ECUB_EXT_CTRL_OFF, B12 | B20);
            rdreg(ECUB_EXT_CTRL_OFF, rd);
            `CHK(rd, B12 | B20, "check bit while busy")
            wr(ECUB_EXT_CTRL_OFF, B12 | B20);
            for (int t = 0; t < 60 && rd[ECUB_ASD_CHK_BIT] !== 1'b0; t++) begin
                rdreg(ECUB_EXT_CTRL_OFF, rd);
            end
            if (rd[ECUB_ASD_CHK_BIT] !== 1'b0) begin
                n_fail++;
                $display("mismatch at %0t: speed check never ended", $time);
                report_and_stop();
            end
            `CHK(speed_detect_result, exp_spd[i], "measured speed")
            rdreg(ECUB_SPD_STATUS_OFF, rd);
            `CHK(rd, 32'h0000_0004 | 32'(exp_spd[i]), "speed status")
            rx_half = 0;
        end
        $display("test speed check done");
        report_and_stop();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        n_fail++;
        $display("mismatch at %0t: run limit reached", $time);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
